// >>> logic/cppc_defines.svh
/*
 * Offsets, field positions, reset values and sizes for the cache portion
 * partition controller. Assumes it is included by its bare name.
 */
`ifndef CPPC_DEFINES_SVH
`define CPPC_DEFINES_SVH

// ****************************************
// Register offsets within one feature page
// ****************************************
`define CPPC_OFS_FEATURE_ID   12'h000
`define CPPC_OFS_PORTION_ID   12'h030
`define CPPC_OFS_PART_SEL     12'h100
`define CPPC_OFS_PORTION_MAP  12'h200
`define CPPC_OFS_BW_MAX       12'h208

// ****************************************
// Sizes
// ****************************************
`define CPPC_PARTITION_ID_W         4
`define CPPC_RIS_W            1
`define CPPC_NUM_PORTIONS     8
`define CPPC_PORTION_IDX_W    3
`define CPPC_BW_W             16
`define CPPC_ENTRIES          64
`define CPPC_IDX_W            6

// ****************************************
// Field positions
// ****************************************
`define CPPC_SEL_PID_LSB      0
`define CPPC_SEL_RIS_LSB      24
`define CPPC_FID_PID_MAX_LSB  0
`define CPPC_FID_HAS_CPOR     16
`define CPPC_FID_HAS_MBW_MAX  17
`define CPPC_FID_INSTANCE_SELECT_PRESENT      18
`define CPPC_FID_RIS_MAX_LSB  24
`define CPPC_PID_NUM_LSB      0

// ****************************************
// Reset and constant values
// ****************************************
`define CPPC_MAP_RST          8'hFF
`define CPPC_BW_RST           16'hFFFF
`define CPPC_PID_MAX          4'hF
`define CPPC_RIS_MAX          1'h1
`define CPPC_NUM_PORTIONS_VAL 16'h0008

`endif

// >>> logic/cppc_pkg.sv
/*
 * Types and the shared index decode of the cache portion partition
 * controller. Assumes cppc_defines.svh is on the include path.
 */
package cppc_pkg;
`include "cppc_defines.svh"

   typedef logic [`CPPC_PARTITION_ID_W-1:0]      cppc_partition_id_t;
   typedef logic [`CPPC_RIS_W-1:0]         cppc_ris_t;
   typedef logic [`CPPC_NUM_PORTIONS-1:0]  cppc_map_t;
   typedef logic [`CPPC_BW_W-1:0]          cppc_bw_t;
   typedef logic [`CPPC_IDX_W-1:0]         cppc_idx_t;
   typedef logic [`CPPC_PORTION_IDX_W-1:0] cppc_pidx_t;

   typedef struct packed {
      cppc_partition_id_t sel_pid_s;
      cppc_partition_id_t sel_pid_ns;
      cppc_ris_t    sel_ris_s;
      cppc_ris_t    sel_ris_ns;
      logic         ack;
      logic         err;
      logic [31:0]  rdata;
      logic         rsp_valid;
      logic         rsp_hit;
      logic         rsp_alloc;
      cppc_map_t    rsp_portion;
      cppc_bw_t     rsp_bw;
   } cppc_top_state_t;

   typedef struct packed {
      cppc_pidx_t ptr;
   } cppc_pick_state_t;

   // Space, instance and partition together pick one settings entry
   function automatic cppc_idx_t cppc_index(input logic ns, input cppc_ris_t resource_instance_select,
                                            input cppc_partition_id_t pid);
      return {ns, resource_instance_select, pid};
   endfunction
endpackage

// >>> logic/cppc_settings_store.sv
/*
 * Per-partition settings storage: portion allowance map and bandwidth
 * maximum, one entry per space, instance and partition.
 * Assumes a single writer and two independent combinational readers.
 */
`timescale 1ns/1ns
module cppc_settings_store
   import cppc_pkg::*;
(
   input  wire logic      clk,
   input  wire logic      rst_n,
   input  wire logic      wr_map,
   input  wire logic      wr_bw,
   input  wire cppc_idx_t wr_idx,
   input  wire logic [31:0] wr_data,
   input  wire cppc_idx_t rd_idx_a,
   output cppc_map_t      map_a,
   output cppc_bw_t       bw_a,
   input  wire cppc_idx_t rd_idx_b,
   output cppc_map_t      map_b,
   output cppc_bw_t       bw_b
);
   typedef struct packed {
      cppc_map_t [`CPPC_ENTRIES-1:0] map;
      cppc_bw_t  [`CPPC_ENTRIES-1:0] bw;
   } cppc_store_t;

   cppc_store_t st_reg;
   cppc_store_t st_next;

   always_comb begin
      st_next = st_reg;
      if (wr_map) begin
         st_next.map[wr_idx] = wr_data[`CPPC_NUM_PORTIONS-1:0];
      end
      if (wr_bw) begin
         st_next.bw[wr_idx] = wr_data[`CPPC_BW_W-1:0];
      end
   end

   // Full access after reset so an unprogrammed cache behaves unpartitioned
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= {{`CPPC_ENTRIES{`CPPC_MAP_RST}}, {`CPPC_ENTRIES{`CPPC_BW_RST}}};
      end else begin
         st_reg <= st_next;
      end
   end

   assign map_a = st_reg.map[rd_idx_a];
   assign bw_a  = st_reg.bw[rd_idx_a];
   assign map_b = st_reg.map[rd_idx_b];
   assign bw_b  = st_reg.bw[rd_idx_b];
endmodule

// >>> logic/cppc_portion_pick.sv
/*
 * Round-robin choice of one allowed cache portion for a line fill.
 * Assumes the caller advances it only when an allocation is taken.
 */
`timescale 1ns/1ns
module cppc_portion_pick
   import cppc_pkg::*;
(
   input  wire logic      clk,
   input  wire logic      rst_n,
   input  wire cppc_map_t allow_map,
   input  wire logic      take,
   output cppc_map_t      pick
);
   cppc_pick_state_t st_reg;
   cppc_pick_state_t st_next;

   // First allowed portion at or after the pointer, as one-hot
   function automatic cppc_map_t first_from(input cppc_map_t m, input cppc_pidx_t p);
      cppc_map_t  r;
      logic       found;
      cppc_pidx_t k;
      r     = '0;
      found = 1'b0;
      for (int i = 0; i < `CPPC_NUM_PORTIONS; i++) begin
         k = p + cppc_pidx_t'(i);
         if (m[k] && !found) begin
            r[k]  = 1'b1;
            found = 1'b1;
         end
      end
      return r;
   endfunction

   always_comb begin
      pick    = first_from(allow_map, st_reg.ptr);
      st_next = st_reg;
      // Moving past the chosen portion spreads fills evenly over the map
      if (take) begin
         for (int i = 0; i < `CPPC_NUM_PORTIONS; i++) begin
            if (pick[i]) begin
               st_next.ptr = cppc_pidx_t'(i + 1);
            end
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end
endmodule

// >>> logic/cppc_partition_ctrl.sv
/*
 * Cache portion partition controller: secure and non-secure register pages
 * with select-then-configure access, and per-request allocation steering.
 * Assumes the cache reports its own lookup hit and a capacity-limit verdict,
 * and maps one portion to each equal share of its ways.
 */
`timescale 1ns/1ns
module cppc_partition_ctrl
   import cppc_pkg::*;
(
   input  wire logic         CLK,
   input  wire logic         RST_N,
   input  wire logic         REG_REQ,
   input  wire logic         REG_WR,
   input  wire logic         REG_NS,
   input  wire logic [11:0]  REG_ADDR,
   input  wire logic [31:0]  REG_WDATA,
   output logic              REG_ACK,
   output logic              REG_ERR,
   output logic [31:0]       REG_RDATA,
   input  wire logic         REQ_VALID,
   input  wire logic         REQ_NS,
   input  wire cppc_partition_id_t REQ_PARTITION_ID,
   input  wire cppc_ris_t    REQ_RIS,
   input  wire logic         REQ_HIT,
   input  wire logic         REQ_NEED_ALLOC,
   input  wire logic         REQ_CAP_OK,
   output logic              RSP_VALID,
   output logic              RSP_HIT,
   output logic              RSP_ALLOC,
   output cppc_map_t         RSP_PORTION,
   output cppc_bw_t          RSP_BW_MAX
);

   // ****************************************
   // Register decode
   // ****************************************

   // One code per decoded page offset; anything else answers with an error
   typedef enum logic [5:0] {
      CPPC_SEL_NONE    = 6'h01,
      CPPC_SEL_FEATURE = 6'h02,
      CPPC_SEL_PORTION = 6'h04,
      CPPC_SEL_PARTSEL = 6'h08,
      CPPC_SEL_MAP     = 6'h10,
      CPPC_SEL_BWMAX   = 6'h20
   } cppc_reg_sel_t;

   // Offset to register; shared by the write strobes and the read mux
   function automatic cppc_reg_sel_t decode_offset(input logic [11:0] addr);
      cppc_reg_sel_t r;
      unique case (addr)
         `CPPC_OFS_FEATURE_ID:  r = CPPC_SEL_FEATURE;
         `CPPC_OFS_PORTION_ID:  r = CPPC_SEL_PORTION;
         `CPPC_OFS_PART_SEL:    r = CPPC_SEL_PARTSEL;
         `CPPC_OFS_PORTION_MAP: r = CPPC_SEL_MAP;
         `CPPC_OFS_BW_MAX:      r = CPPC_SEL_BWMAX;
         default:               r = CPPC_SEL_NONE;
      endcase
      return r;
   endfunction

   // Each implemented control announces itself; the maxima tell software
   // how many partitions and instances each page can reach
   function automatic logic [31:0] feature_word();
      logic [31:0] w;
      w = 32'h00000000;
      w[`CPPC_FID_PID_MAX_LSB +: `CPPC_PARTITION_ID_W] = `CPPC_PID_MAX;
      w[`CPPC_FID_HAS_CPOR]                      = 1'b1;
      w[`CPPC_FID_HAS_MBW_MAX]                   = 1'b1;
      w[`CPPC_FID_INSTANCE_SELECT_PRESENT]                       = 1'b1;
      w[`CPPC_FID_RIS_MAX_LSB +: `CPPC_RIS_W]    = `CPPC_RIS_MAX;
      return w;
   endfunction

   // Portion count is a separate constant, CPPC_NUM_PORTIONS_VAL, set equal to the allowance map width
   function automatic logic [31:0] portion_word();
      logic [31:0] w;
      w = 32'h00000000;
      w[`CPPC_PID_NUM_LSB +: 16] = `CPPC_NUM_PORTIONS_VAL;
      return w;
   endfunction

   function automatic logic [31:0] select_word(input cppc_partition_id_t pid, input cppc_ris_t resource_instance_select);
      logic [31:0] w;
      w = 32'h00000000;
      w[`CPPC_SEL_PID_LSB +: `CPPC_PARTITION_ID_W] = pid;
      w[`CPPC_SEL_RIS_LSB +: `CPPC_RIS_W]    = resource_instance_select;
      return w;
   endfunction

   // ****************************************
   // State and internal nets
   // ****************************************

   cppc_top_state_t st_reg;
   cppc_top_state_t st_next;
   cppc_reg_sel_t   reg_sel;
   logic            reg_take;
   logic            reg_write;
   logic            wr_map;
   logic            wr_bw;
   cppc_partition_id_t    sel_pid;
   cppc_ris_t       sel_ris;
   cppc_idx_t       cfg_idx;
   cppc_map_t       cfg_map;
   cppc_bw_t        cfg_bw;
   cppc_idx_t       req_idx;
   cppc_map_t       req_map;
   cppc_bw_t        req_bw;
   cppc_map_t       pick;
   logic            alloc_ok;

   // ****************************************
   // Register page access
   // ****************************************

   // Acknowledge lasts one cycle; a request still held while it shows is not
   // taken again, so a master that drops the request on acknowledge sees one
   // access per request
   assign reg_take  = REG_REQ && !st_reg.ack;
   assign reg_write = reg_take && REG_WR;
   assign reg_sel   = decode_offset(REG_ADDR);

   // The page used for the access picks its own select contents
   assign sel_pid = REG_NS ? st_reg.sel_pid_ns : st_reg.sel_pid_s;
   assign sel_ris = REG_NS ? st_reg.sel_ris_ns : st_reg.sel_ris_s;
   assign cfg_idx = cppc_index(REG_NS, sel_ris, sel_pid);

   assign wr_map = reg_write && (reg_sel == CPPC_SEL_MAP);
   assign wr_bw  = reg_write && (reg_sel == CPPC_SEL_BWMAX);

   // ****************************************
   // Request steering
   // ****************************************

   // Partition info rides with every request and alone picks the settings
   assign req_idx = cppc_index(REQ_NS, REQ_RIS, REQ_PARTITION_ID);

   // A hit never allocates; a fill needs a permitted portion and the
   // cache's capacity verdict at the same time
   assign alloc_ok = REQ_VALID && !REQ_HIT && REQ_NEED_ALLOC
                     && REQ_CAP_OK
                     && (req_map != '0);

   // ****************************************
   // Settings storage and portion choice
   // ****************************************

   // A map write only changes what later fills may use; there is no path
   // from here to resident lines, so nothing moves or is evicted
   cppc_settings_store u_store (
      .clk      (CLK),
      .rst_n    (RST_N),
      .wr_map   (wr_map),
      .wr_bw    (wr_bw),
      .wr_idx   (cfg_idx),
      .wr_data  (REG_WDATA),
      .rd_idx_a (cfg_idx),
      .map_a    (cfg_map),
      .bw_a     (cfg_bw),
      .rd_idx_b (req_idx),
      .map_b    (req_map),
      .bw_b     (req_bw)
   );

   // Portions are equal shares; every partition granted one shares it
   cppc_portion_pick u_pick (
      .clk       (CLK),
      .rst_n     (RST_N),
      .allow_map (req_map),
      .take      (alloc_ok),
      .pick      (pick)
   );

   // ****************************************
   // Next state
   // ****************************************

   always_comb begin
      logic [31:0] rd_word;
      logic        rd_err;
      rd_word = 32'h00000000;
      rd_err  = 1'b0;
      st_next = st_reg;

      unique case (reg_sel)
         CPPC_SEL_FEATURE: rd_word = feature_word();
         CPPC_SEL_PORTION: rd_word = portion_word();
         CPPC_SEL_PARTSEL: rd_word = select_word(sel_pid, sel_ris);
         CPPC_SEL_MAP:     rd_word = {{(32 - `CPPC_NUM_PORTIONS){1'b0}}, cfg_map};
         CPPC_SEL_BWMAX:   rd_word = {{(32 - `CPPC_BW_W){1'b0}}, cfg_bw};
         CPPC_SEL_NONE:    rd_err  = 1'b1;
      endcase

      // Register page answer
      st_next.ack = reg_take;
      if (reg_take) begin
         st_next.err   = rd_err;
         st_next.rdata = REG_WR ? 32'h00000000 : rd_word;
      end

      // Select write lands in the page it came through only
      if (reg_write && (reg_sel == CPPC_SEL_PARTSEL)) begin
         if (REG_NS) begin
            st_next.sel_pid_ns = REG_WDATA[`CPPC_SEL_PID_LSB +: `CPPC_PARTITION_ID_W];
            st_next.sel_ris_ns = REG_WDATA[`CPPC_SEL_RIS_LSB +: `CPPC_RIS_W];
         end else begin
            st_next.sel_pid_s = REG_WDATA[`CPPC_SEL_PID_LSB +: `CPPC_PARTITION_ID_W];
            st_next.sel_ris_s = REG_WDATA[`CPPC_SEL_RIS_LSB +: `CPPC_RIS_W];
         end
      end

      // Response one cycle after the request
      st_next.rsp_valid   = REQ_VALID;
      st_next.rsp_hit     = REQ_VALID && REQ_HIT;
      st_next.rsp_alloc   = alloc_ok;
      st_next.rsp_portion = alloc_ok ? pick : '0;
      // Bandwidth limit holds the last request's value between requests
      if (REQ_VALID) begin
         st_next.rsp_bw = req_bw;
      end
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   // ****************************************
   // Outputs, each straight from the state register
   // ****************************************

   assign REG_ACK     = st_reg.ack;
   assign REG_ERR     = st_reg.err;
   assign REG_RDATA   = st_reg.rdata;
   assign RSP_VALID   = st_reg.rsp_valid;
   assign RSP_HIT     = st_reg.rsp_hit;
   assign RSP_ALLOC   = st_reg.rsp_alloc;
   assign RSP_PORTION = st_reg.rsp_portion;
   assign RSP_BW_MAX  = st_reg.rsp_bw;

   // ****************************************
   // Assertions
   // ****************************************

   // Acknowledge is a single-cycle pulse
   property p_ack_single;
      @(posedge CLK) disable iff (!RST_N)
      REG_ACK |=> !REG_ACK;
   endproperty
   a_ack_single: assert property (p_ack_single) else $error("acknowledge held");

   // An unknown offset is answered with an error
   property p_err_unmapped;
      @(posedge CLK) disable iff (!RST_N)
      REG_REQ && !REG_ACK && (reg_sel == CPPC_SEL_NONE) |=> REG_ERR;
   endproperty
   a_err_unmapped: assert property (p_err_unmapped) else $error("no error on bad offset");

   // A chosen portion is always one the partition may use
   property p_fill_in_map;
      @(posedge CLK) disable iff (!RST_N)
      alloc_ok |-> ((pick & ~req_map) == '0);
   endproperty
   a_fill_in_map: assert property (p_fill_in_map) else $error("fill outside map");

   // Exactly one portion per fill
   property p_fill_onehot;
      @(posedge CLK) disable iff (!RST_N)
      alloc_ok |-> $onehot(pick);
   endproperty
   a_fill_onehot: assert property (p_fill_onehot) else $error("fill not one portion");

   property p_empty_map;
      @(posedge CLK) disable iff (!RST_N)
      REQ_VALID && (req_map == '0) |=> !RSP_ALLOC;
   endproperty
   a_empty_map: assert property (p_empty_map) else $error("fill with empty map");

   property p_cap_gate;
      @(posedge CLK) disable iff (!RST_N)
      REQ_VALID && !REQ_CAP_OK |=> !RSP_ALLOC;
   endproperty
   a_cap_gate: assert property (p_cap_gate) else $error("fill over capacity");

   // A hit stays a hit whatever the map says, and never fills
   property p_hit_kept;
      @(posedge CLK) disable iff (!RST_N)
      REQ_VALID && REQ_HIT |=> RSP_HIT && !RSP_ALLOC;
   endproperty
   a_hit_kept: assert property (p_hit_kept) else $error("hit lost or filled");

   property p_bw_entry;
      @(posedge CLK) disable iff (!RST_N)
      REQ_VALID |=> (RSP_BW_MAX == $past(req_bw));
   endproperty
   a_bw_entry: assert property (p_bw_entry) else $error("wrong bandwidth entry");

   // A non-secure page write leaves the secure select alone
   property p_sel_page;
      @(posedge CLK) disable iff (!RST_N)
      reg_write && REG_NS |=> $stable(st_reg.sel_pid_s) && $stable(st_reg.sel_ris_s);
   endproperty
   a_sel_page: assert property (p_sel_page) else $error("select crossed pages");
endmodule

// >>> tb/cppc_requester.sv
/*
 * Upstream requester model: issues one tagged lookup per go pulse.
 * Assumes the bench raises go for exactly one clock per request.
 */
`timescale 1ns/1ns
module cppc_requester
   import cppc_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       go,
   input  wire logic [8:0] fields,
   output logic            req_valid = 1'b0,
   output logic [8:0]      req_fields = 9'h000
);
   // Idle fields flip each cycle so a stale request never looks valid
   always @(posedge clk) begin
      req_valid  <= go;
      req_fields <= go ? fields : ~req_fields;
   end
endmodule

// >>> tb/testbench.sv
/*
 * Self-checking bench for the partition controller with a settings model.
 * Assumes a held request until REG_ACK and RSP_VALID within eight clocks.
 */
`timescale 1ns/1ns
module testbench;
   import cppc_pkg::*;
   logic        CLK = 0, RST_N = 0, REG_REQ = 0, REG_WR = 0, REG_NS = 0, go = 0;
   logic [11:0] REG_ADDR = 12'h000;
   logic [31:0] REG_WDATA = 32'h0, REG_RDATA, rd;
   logic [8:0]  fields = 9'h000, rq;
   logic        REG_ACK, REG_ERR, RSP_VALID, RSP_HIT, RSP_ALLOC, REQ_VALID, ns, resource_instance_select, hit, cap, er;
   logic [3:0]  pid;
   cppc_map_t   RSP_PORTION, m;
   cppc_bw_t    RSP_BW_MAX, b;
   int          err_count = 0, n_compared = 0, idx, k, mdl_map[64], mdl_bw[64];
   always #4 CLK = ~CLK;
   cppc_requester up (.clk(CLK), .go(go), .fields(fields), .req_valid(REQ_VALID),
                      .req_fields(rq));
   cppc_partition_ctrl dut (.CLK(CLK), .RST_N(RST_N), .REG_REQ(REG_REQ), .REG_WR(REG_WR),
      .REG_NS(REG_NS), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
      .REG_ACK(REG_ACK), .REG_ERR(REG_ERR), .REG_RDATA(REG_RDATA), .REQ_VALID(REQ_VALID),
      .REQ_NS(rq[8]), .REQ_RIS(rq[7]), .REQ_PARTITION_ID(rq[6:3]), .REQ_HIT(rq[2]),
      .REQ_NEED_ALLOC(rq[1]), .REQ_CAP_OK(rq[0]), .RSP_VALID(RSP_VALID), .RSP_HIT(RSP_HIT),
      .RSP_ALLOC(RSP_ALLOC), .RSP_PORTION(RSP_PORTION), .RSP_BW_MAX(RSP_BW_MAX));
   // ****************
   // Shared tasks
   // ****************
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // One access at a time, held until acknowledged
   task reg_acc(input logic w, input logic s, input logic [11:0] a, input logic [31:0] d);
      int i;
      i = 0;
      @(posedge CLK);
      REG_REQ <= 1'b1;
      REG_WR <= w;
      REG_NS <= s;
      REG_ADDR <= a;
      REG_WDATA <= d;
      do @(posedge CLK); while (REG_ACK !== 1'b1 && ++i < 50);
      rd = REG_RDATA;
      er = REG_ERR;
      REG_REQ <= 1'b0;
      if (i >= 50) chk(0, 1);
   endtask
   task req_chk(input int j);
      int i;
      i = 0;
      hit = $urandom;
      cap = $urandom;
      @(posedge CLK);
      go <= 1'b1;
      fields <= {j[5:0], hit, 1'b1, cap};
      @(posedge CLK);
      go <= 1'b0;
      do @(posedge CLK); while (RSP_VALID !== 1'b1 && ++i < 8);
      chk(RSP_HIT, hit);
      chk(RSP_BW_MAX, mdl_bw[j]);
      chk(RSP_ALLOC, !hit && cap && mdl_map[j] != 0);
      if (RSP_ALLOC === 1'b1) begin
         chk(RSP_PORTION & ~mdl_map[j], 0);
         chk($onehot(RSP_PORTION), 1);
      end else begin
         chk(RSP_PORTION, 0);
      end
   endtask
   task tally_and_finish;
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // ****************
   // Tests
   // ****************
   initial begin
      #200000;
      err_count++;
      tally_and_finish;
   end
   initial begin
      foreach (mdl_map[i]) begin
         mdl_map[i] = 8'hFF;
         mdl_bw[i] = 16'hFFFF;
      end
      void'($urandom(32'h8011));
      repeat (16) @(posedge CLK);
      RST_N <= 1'b1;
      reg_acc(0, 1, 12'h030, 0);
      chk(rd[15:0], 16'h0008);
      reg_acc(0, 0, 12'h000, 0);
      chk(rd[18:16], 3'h7);
      chk(er, 0);
      reg_acc(0, 0, 12'h0FC, 0);
      chk(er, 1);
      $display("test id done");
      for (k = 0; k < 24; k++) begin
         ns = $urandom;
         resource_instance_select = $urandom;
         pid = $urandom;
         m = ($urandom % 4 == 0) ? 8'h00 : 8'($urandom);
         b = $urandom;
         idx = {ns, resource_instance_select, pid};
         // Select finishes before the settings write
         reg_acc(1, ns, 12'h100, {7'h00, resource_instance_select, 20'h0, pid});
         reg_acc(1, ns, 12'h200, {24'h0, m});
         reg_acc(1, ns, 12'h208, {16'h0, b});
         mdl_map[idx] = m;
         mdl_bw[idx] = b;
         reg_acc(0, ns, 12'h208, 0);
         chk(rd[15:0], b);
         reg_acc(0, ns, 12'h200, 0);
         chk(rd[7:0], m);
         reg_acc(0, ns, 12'h100, 0);
         chk(rd, {7'h00, resource_instance_select, 20'h0, pid});
         req_chk(idx);
         req_chk($urandom % 64);
      end
      $display("test settings done");
      tally_and_finish;
   end
endmodule
